// *** common/dgp_defs.vh ***
// constants of the dual gpio port block: register offsets, field
// positions and reset values.
// assumes a 32-bit axi4-lite register bus with byte addresses.
`ifndef DGP_DEFS_VH
`define DGP_DEFS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define DGP_ADDR_W 5
`define DGP_OFF_SMALL_DIR 5'h00
`define DGP_OFF_SMALL_DATA 5'h04
`define DGP_OFF_WIDE_DIR 5'h08
`define DGP_OFF_WIDE_DATA 5'h0c
`define DGP_OFF_TIMER_CTRL 5'h10

// ----------------------------------------------------------------
// timer pin control fields
// ----------------------------------------------------------------
`define DGP_TC_DISABLE 0
`define DGP_TC_MODE_LO 1
`define DGP_TC_MODE_HI 2
`define DGP_TC_SEL_A 3
`define DGP_TC_PWM_EN 4
`define DGP_TC_IO_LO 5
`define DGP_TC_IO_HI 8
`define DGP_TC_W 9

// ----------------------------------------------------------------
// reset values and fixed read patterns
// ----------------------------------------------------------------
`define DGP_RST_DIR4 4'h0
`define DGP_RST_DIR8 8'h00
`define DGP_RST_DATA4 4'h0
`define DGP_RST_DATA8 8'h00
`define DGP_RST_TCTL 9'h001
`define DGP_SMALL_PAD 4'hf
`define DGP_RESP_OKAY 2'h0
`define DGP_RESP_SLVERR 2'h2

`endif

// *** hw/dgp_top_pin_sel.v ***
// decode that decides whether the timer owns the top wide-port pin.
// assumes the timer control fields arrive registered on the same clock.
`default_nettype none

module dgp_top_pin_sel (
  input wire timer_d1_output_disable_i,
  input wire combo_mode_hi_i,
  input wire combo_mode_lo_i,
  input wire select_a_i,
  input wire pwm_d1_enable_i,
  input wire [3:0] d1_io_ctrl_i,
  output reg timer_drive_o
);

  // ----------------------------------------------------------------
  // pin owner decode
  // ----------------------------------------------------------------
  // io codes 101x and 1001 drive; 0xxx, 11xx and 1000 leave gpio
  always @* begin
    timer_drive_o = 1'b0;
    if (timer_d1_output_disable_i) begin
      timer_drive_o = 1'b0;
    end else if (combo_mode_hi_i | combo_mode_lo_i) begin
      timer_drive_o = 1'b1;
    end else if (!select_a_i) begin
      timer_drive_o = 1'b0;
    end else if (pwm_d1_enable_i) begin
      timer_drive_o = 1'b1;
    end else begin
      timer_drive_o = (d1_io_ctrl_i[3:1] == 3'h5) |
                      (d1_io_ctrl_i == 4'h9);
    end
  end

endmodule

`default_nettype wire

// *** hw/dgp_top.v ***
// dual gpio port: a four-pin small port and an eight-pin wide port
// whose pins are shared with an on-chip timer, reached over axi4-lite.
// assumes pins are asynchronous to ref_clk_i and the timer signals are
// synchronous to it.
//
// The AXI4-Lite register port and the register offsets are this design's own decisions.
`include "dgp_defs.vh"
`default_nettype none

module dgp_top (
  input wire ref_clk_i,
  input wire reset_i,
  // axi4-lite slave
  input wire s_axi_awvalid_i,
  output wire s_axi_awready_o,
  input wire [`DGP_ADDR_W-1:0] s_axi_awaddr_i,
  input wire s_axi_wvalid_i,
  output wire s_axi_wready_o,
  input wire [31:0] s_axi_wdata_i,
  input wire [3:0] s_axi_wstrb_i,
  output wire s_axi_bvalid_o,
  input wire s_axi_bready_i,
  output wire [1:0] s_axi_bresp_o,
  input wire s_axi_arvalid_i,
  output wire s_axi_arready_o,
  input wire [`DGP_ADDR_W-1:0] s_axi_araddr_i,
  output wire s_axi_rvalid_o,
  input wire s_axi_rready_i,
  output wire [31:0] s_axi_rdata_o,
  output wire [1:0] s_axi_rresp_o,
  // small port pins
  input wire [3:0] small_pin_i,
  output wire [3:0] small_pin_o,
  output wire [3:0] small_pin_oe_o,
  // wide port pins
  input wire [7:0] wide_pin_i,
  output wire [7:0] wide_pin_o,
  output wire [7:0] wide_pin_oe_o,
  // timer channel on the top pin
  input wire timer_ch1_d_out_i,
  output wire timer_ch1_d_pin_o,
  // timer claims on the lower wide pins
  input wire [6:0] timer_claim_i,
  input wire [6:0] timer_out_i
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // register hit on a word-aligned offset
  function is_off;
    input [`DGP_ADDR_W-1:0] addr;
    input [`DGP_ADDR_W-1:0] off;
    begin
      is_off = (addr[`DGP_ADDR_W-1:2] == off[`DGP_ADDR_W-1:2]);
    end
  endfunction

  // mux of latched bit and pin level by direction
  function [7:0] port_view;
    input [7:0] dir;
    input [7:0] dat;
    input [7:0] pin;
    begin
      port_view = (dir & dat) | (~dir & pin);
    end
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg [3:0] small_port_dir_reg_r;
  reg [3:0] small_port_data_reg_r;
  reg [7:0] wide_port_dir_reg_r;
  reg [7:0] wide_port_data_reg_r;
  reg [`DGP_TC_W-1:0] timer_ctrl_r;
  reg [3:0] small_meta_r;
  reg [3:0] small_sync_r;
  reg [7:0] wide_meta_r;
  reg [7:0] wide_sync_r;
  reg aw_have_r;
  reg [`DGP_ADDR_W-1:0] awaddr_r;
  reg awready_r;
  reg w_have_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;
  reg wready_r;
  reg bvalid_r;
  reg [1:0] bresp_r;
  reg arready_r;
  reg rvalid_r;
  reg [31:0] rdata_r;
  reg [1:0] rresp_r;
  reg [3:0] small_out_r;
  reg [3:0] small_oe_r;
  reg [7:0] wide_out_r;
  reg [7:0] wide_oe_r;
  reg timer_in_r;
  wire top_drive;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // two flops before anything reads a pin level
  always @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      small_meta_r <= 4'h0;
      small_sync_r <= 4'h0;
      wide_meta_r <= 8'h00;
      wide_sync_r <= 8'h00;
    end else begin
      small_meta_r <= small_pin_i;
      small_sync_r <= small_meta_r;
      wide_meta_r <= wide_pin_i;
      wide_sync_r <= wide_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // axi write channel
  // ----------------------------------------------------------------
  wire aw_take = s_axi_awvalid_i & awready_r;
  wire w_take = s_axi_wvalid_i & wready_r;
  wire do_wr = aw_have_r & w_have_r & ~bvalid_r;
  wire aw_have_nxt = do_wr ? 1'b0 : (aw_take | aw_have_r);
  wire w_have_nxt = do_wr ? 1'b0 : (w_take | w_have_r);
  wire bvalid_nxt = do_wr | (bvalid_r & ~s_axi_bready_i);
  wire wr_hit = is_off(awaddr_r, `DGP_OFF_SMALL_DIR) |
                is_off(awaddr_r, `DGP_OFF_SMALL_DATA) |
                is_off(awaddr_r, `DGP_OFF_WIDE_DIR) |
                is_off(awaddr_r, `DGP_OFF_WIDE_DATA) |
                is_off(awaddr_r, `DGP_OFF_TIMER_CTRL);

  // address and data are taken in either order; one write in flight
  always @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      aw_have_r <= 1'b0;
      awaddr_r <= {`DGP_ADDR_W{1'b0}};
      awready_r <= 1'b0;
      w_have_r <= 1'b0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= `DGP_RESP_OKAY;
    end else begin
      aw_have_r <= aw_have_nxt;
      w_have_r <= w_have_nxt;
      bvalid_r <= bvalid_nxt;
      awready_r <= ~aw_have_nxt & ~bvalid_nxt;
      wready_r <= ~w_have_nxt & ~bvalid_nxt;
      if (aw_take) begin
        awaddr_r <= s_axi_awaddr_i;
      end
      if (w_take) begin
        wdata_r <= s_axi_wdata_i;
        wstrb_r <= s_axi_wstrb_i;
      end
      if (do_wr) begin
        bresp_r <= wr_hit ? `DGP_RESP_OKAY : `DGP_RESP_SLVERR;
      end
    end
  end

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  // byte lane 0 carries every port field; lane 1 the top io code bit
  always @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      small_port_dir_reg_r <= `DGP_RST_DIR4;
      small_port_data_reg_r <= `DGP_RST_DATA4;
      wide_port_dir_reg_r <= `DGP_RST_DIR8;
      wide_port_data_reg_r <= `DGP_RST_DATA8;
      timer_ctrl_r <= `DGP_RST_TCTL;
    end else if (do_wr) begin
      if (wstrb_r[0] && is_off(awaddr_r, `DGP_OFF_SMALL_DIR)) begin
        small_port_dir_reg_r <= wdata_r[3:0];
      end
      if (wstrb_r[0] && is_off(awaddr_r, `DGP_OFF_SMALL_DATA)) begin
        small_port_data_reg_r <= wdata_r[3:0];
      end
      if (wstrb_r[0] && is_off(awaddr_r, `DGP_OFF_WIDE_DIR)) begin
        wide_port_dir_reg_r <= wdata_r[7:0];
      end
      if (wstrb_r[0] && is_off(awaddr_r, `DGP_OFF_WIDE_DATA)) begin
        wide_port_data_reg_r <= wdata_r[7:0];
      end
      if (is_off(awaddr_r, `DGP_OFF_TIMER_CTRL)) begin
        if (wstrb_r[0]) begin
          timer_ctrl_r[7:0] <= wdata_r[7:0];
        end
        if (wstrb_r[1]) begin
          timer_ctrl_r[8] <= wdata_r[8];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // axi read channel
  // ----------------------------------------------------------------
  wire ar_take = s_axi_arvalid_i & arready_r;
  wire rvalid_nxt = ar_take | (rvalid_r & ~s_axi_rready_i);
  reg [31:0] rd_word;
  reg rd_hit;
  // small port view widened to the helper's byte, only the low nibble used
  wire [7:0] small_view = port_view({4'h0, small_port_dir_reg_r},
                                    {4'h0, small_port_data_reg_r},
                                    {4'h0, small_sync_r});

  // direction registers are write-only and read back as zero
  always @* begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    if (is_off(s_axi_araddr_i, `DGP_OFF_SMALL_DATA)) begin
      rd_word[7:4] = `DGP_SMALL_PAD;
      rd_word[3:0] = small_view[3:0];
    end else if (is_off(s_axi_araddr_i, `DGP_OFF_WIDE_DATA)) begin
      rd_word[7:0] = port_view(wide_port_dir_reg_r,
                               wide_port_data_reg_r,
                               wide_sync_r);
    end else if (is_off(s_axi_araddr_i, `DGP_OFF_TIMER_CTRL)) begin
      rd_word[`DGP_TC_W-1:0] = timer_ctrl_r;
    end else if (is_off(s_axi_araddr_i, `DGP_OFF_SMALL_DIR) ||
                 is_off(s_axi_araddr_i, `DGP_OFF_WIDE_DIR)) begin
      rd_word = 32'h0000_0000;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // one read in flight; data captured at the address handshake
  always @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= `DGP_RESP_OKAY;
    end else begin
      rvalid_r <= rvalid_nxt;
      arready_r <= ~rvalid_nxt;
      if (ar_take) begin
        rdata_r <= rd_word;
        rresp_r <= rd_hit ? `DGP_RESP_OKAY : `DGP_RESP_SLVERR;
      end
    end
  end

  // ----------------------------------------------------------------
  // top pin owner decode
  // ----------------------------------------------------------------
  dgp_top_pin_sel u_sel (
    .timer_d1_output_disable_i(timer_ctrl_r[`DGP_TC_DISABLE]),
    .combo_mode_hi_i(timer_ctrl_r[`DGP_TC_MODE_HI]),
    .combo_mode_lo_i(timer_ctrl_r[`DGP_TC_MODE_LO]),
    .select_a_i(timer_ctrl_r[`DGP_TC_SEL_A]),
    .pwm_d1_enable_i(timer_ctrl_r[`DGP_TC_PWM_EN]),
    .d1_io_ctrl_i(timer_ctrl_r[`DGP_TC_IO_HI:`DGP_TC_IO_LO]),
    .timer_drive_o(top_drive)
  );

  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  // registered so every pin output comes from a flop; one cycle of
  // lag after a register write is the price
  always @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      small_out_r <= 4'h0;
      small_oe_r <= 4'h0;
      wide_out_r <= 8'h00;
      wide_oe_r <= 8'h00;
      timer_in_r <= 1'b0;
    end else begin
      small_oe_r <= small_port_dir_reg_r;
      small_out_r <= small_port_data_reg_r;
      // timer claim wins over gpio settings on the lower pins
      wide_oe_r[6:0] <= timer_claim_i | wide_port_dir_reg_r[6:0];
      wide_out_r[6:0] <= (timer_claim_i & timer_out_i) |
                         (~timer_claim_i & wide_port_data_reg_r[6:0]);
      if (top_drive) begin
        wide_oe_r[7] <= 1'b1;
        wide_out_r[7] <= timer_ch1_d_out_i;
        timer_in_r <= 1'b0;
      end else begin
        wide_oe_r[7] <= wide_port_dir_reg_r[7];
        wide_out_r[7] <= wide_port_data_reg_r[7];
        // an input gpio top pin also feeds the timer channel
        timer_in_r <= ~wide_port_dir_reg_r[7] & wide_sync_r[7];
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign s_axi_awready_o = awready_r;
  assign s_axi_wready_o = wready_r;
  assign s_axi_bvalid_o = bvalid_r;
  assign s_axi_bresp_o = bresp_r;
  assign s_axi_arready_o = arready_r;
  assign s_axi_rvalid_o = rvalid_r;
  assign s_axi_rdata_o = rdata_r;
  assign s_axi_rresp_o = rresp_r;
  assign small_pin_o = small_out_r;
  assign small_pin_oe_o = small_oe_r;
  assign wide_pin_o = wide_out_r;
  assign wide_pin_oe_o = wide_oe_r;
  assign timer_ch1_d_pin_o = timer_in_r;

endmodule

`default_nettype wire

// *** bench/dgp_pad_model.sv ***
// pad model: each pin shows its driven value where enabled, else the
// outside level that the bench sets for the board.
`default_nettype none
module dgp_pad_model (
  input wire logic [3:0] sp_drv_i,
  input wire logic [3:0] sp_oe_i,
  input wire logic [3:0] sp_ext_i,
  input wire logic [7:0] wp_drv_i,
  input wire logic [7:0] wp_oe_i,
  input wire logic [7:0] wp_ext_i,
  output logic [3:0] sp_lvl_o,
  output logic [7:0] wp_lvl_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // a driven pin beats the outside level, so reads see the real wire
  assign sp_lvl_o = (sp_drv_i & sp_oe_i) | (sp_ext_i & ~sp_oe_i);
  assign wp_lvl_o = (wp_drv_i & wp_oe_i) | (wp_ext_i & ~wp_oe_i);
endmodule
`default_nettype wire

// *** bench/dgp_chk.sv ***
// checker for the dual gpio port, on its top-level ports only.
// assumes one read and one write at most in flight on the bus.
`include "dgp_defs.vh"
`default_nettype none
module dgp_chk (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [`DGP_ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0] s_axi_rresp_o,
  input wire logic [3:0] small_pin_o,
  input wire logic [3:0] small_pin_oe_o,
  input wire logic [7:0] wide_pin_o,
  input wire logic [7:0] wide_pin_oe_o,
  input wire logic [6:0] timer_claim_i,
  input wire logic [6:0] timer_out_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [`DGP_ADDR_W-1:0] rd_addr_r;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  // -----------------------------------------------------------------
  // read tracking
  // -----------------------------------------------------------------
  // address of the read in flight; arready stays low until it retires
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i)
      rd_addr_r <= '0;
    else if (s_axi_arvalid_i && s_axi_arready_o)
      rd_addr_r <= s_axi_araddr_i;
  end
  a_bresp_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i
    |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response left before it was taken");
  a_rdata_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i
    |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data left before it was taken");
  a_read_turn: assert property (s_axi_arvalid_i && s_axi_arready_o
    |=> s_axi_rvalid_o && !s_axi_arready_o)
    else $error("read answer late or address ready too soon");
  a_small_pad: assert property (s_axi_rvalid_o
    && rd_addr_r == `DGP_OFF_SMALL_DATA |-> s_axi_rdata_o[7:4] == 4'hf)
    else $error("small port upper bits not all ones");
  a_small_latched: assert property (s_axi_rvalid_o
    && rd_addr_r == `DGP_OFF_SMALL_DATA
    |-> ((s_axi_rdata_o[3:0] ^ small_pin_o) & small_pin_oe_o) == 4'h0)
    else $error("small port output bit read back wrong");
  a_dir_blank: assert property (s_axi_rvalid_o
    && rd_addr_r[3:0] inside {4'h0, 4'h8} && !rd_addr_r[4]
    |-> s_axi_rdata_o == 32'h0)
    else $error("direction read returned contents");
  a_unmapped_read: assert property (s_axi_rvalid_o && rd_addr_r[4:2] > 3'h4
    |-> s_axi_rresp_o == `DGP_RESP_SLVERR && s_axi_rdata_o == 32'h0)
    else $error("unmapped read not refused");
  a_claim_drive: assert property (!$past(reset_i)
    |-> (wide_pin_oe_o[6:0] & $past(timer_claim_i)) == $past(timer_claim_i)
    && ((wide_pin_o[6:0] ^ $past(timer_out_i)) & $past(timer_claim_i)) == 0)
    else $error("timer claim did not take the pin");
  c_write: cover property (s_axi_bvalid_o && s_axi_bready_i);
  c_small_read: cover property (s_axi_rvalid_o
    && rd_addr_r == `DGP_OFF_SMALL_DATA);
  c_claim: cover property (|timer_claim_i);
endmodule
bind dgp_top dgp_chk u_chk (.ref_clk_i, .reset_i, .s_axi_bvalid_o,
  .s_axi_bready_i, .s_axi_bresp_o, .s_axi_arvalid_i, .s_axi_arready_o,
  .s_axi_araddr_i, .s_axi_rvalid_o, .s_axi_rready_i, .s_axi_rdata_o,
  .s_axi_rresp_o, .small_pin_o, .small_pin_oe_o, .wide_pin_o,
  .wide_pin_oe_o, .timer_claim_i, .timer_out_i);
`default_nettype wire

// *** bench/tb_top.sv ***
// self-checking bench for the dual gpio port over axi4-lite.
// assumes the pad model closes the pin loop and the checker is bound.
`include "dgp_defs.vh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, tdo = 1'b1;
  logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
  logic awr, wrd, bv, arr, rv, tpin;
  logic [4:0] awa = 5'h00, ara = 5'h00;
  logic [31:0] wd = 32'h0, rd, got;
  logic [1:0] br, rr, resp;
  logic [3:0] sext = 4'ha, slvl, so, soe;
  logic [7:0] wext = 8'hdc, wlvl, wo, woe;
  logic [6:0] tcl = 7'h00, tout = 7'h00;
  logic [2:0] exp3;
  logic [8:0] tc_tab [16] = '{9'h007, 9'h000, 9'h140, 9'h010, 9'h019,
    9'h002, 9'h004, 9'h006, 9'h018, 9'h0e8, 9'h148, 9'h168, 9'h128,
    9'h188, 9'h1e8, 9'h108};
  logic [15:0] tc_drv = 16'h1de0;
  wire logic [2:0] top_seen = {woe[7], wo[7] & woe[7], tpin};
  int errors = 0, samples_checked = 0;
  always #5 clk = ~clk;
  dgp_top dut (.ref_clk_i(clk), .reset_i(rst), .s_axi_awvalid_i(awv),
    .s_axi_awready_o(awr), .s_axi_awaddr_i(awa), .s_axi_wvalid_i(wv),
    .s_axi_wready_o(wrd), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hf),
    .s_axi_bvalid_o(bv), .s_axi_bready_i(bre), .s_axi_bresp_o(br),
    .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_araddr_i(ara),
    .s_axi_rvalid_o(rv), .s_axi_rready_i(rre), .s_axi_rdata_o(rd),
    .s_axi_rresp_o(rr), .small_pin_i(slvl), .small_pin_o(so),
    .small_pin_oe_o(soe), .wide_pin_i(wlvl), .wide_pin_o(wo),
    .wide_pin_oe_o(woe), .timer_ch1_d_out_i(tdo),
    .timer_ch1_d_pin_o(tpin), .timer_claim_i(tcl), .timer_out_i(tout));
  dgp_pad_model pads (.sp_drv_i(so), .sp_oe_i(soe), .sp_ext_i(sext),
    .wp_drv_i(wo), .wp_oe_i(woe), .wp_ext_i(wext), .sp_lvl_o(slvl),
    .wp_lvl_o(wlvl));
  // -----------------------------------------------------------------
  // bus tasks
  // -----------------------------------------------------------------
  task automatic test_done();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, e, input string m);
    samples_checked++;
    if (s !== e) begin
      errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, s, e);
    end
  endtask
  // a hung handshake must not hang the run: count it and stop
  task automatic lost(input string m);
    errors++;
    $display("unexpected at %0t: %s never answered", $time, m);
    test_done();
  endtask
  // address and data go up together; each drops once taken
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    awv <= 1'b1;
    wv <= 1'b1;
    awa <= a;
    wd <= d;
    bre <= 1'b1;
    for (n = 0; n < 40 && !bv; n++) begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
    end
    if (!bv) lost("write");
    resp = br;
    bre <= 1'b0;
  endtask
  task automatic rdr(input logic [4:0] a);
    int n;
    @(posedge clk);
    arv <= 1'b1;
    ara <= a;
    rre <= 1'b1;
    for (n = 0; n < 40 && !rv; n++) begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end
    if (!rv) lost("read");
    got = rd;
    resp = rr;
    rre <= 1'b0;
  endtask
  task automatic wchk(input logic [4:0] a, input logic [31:0] d);
    wr(a, d);
    chk(32'(resp), 32'(`DGP_RESP_OKAY), "write resp");
  endtask
  task automatic rchk(input logic [4:0] a, input logic [31:0] e);
    rdr(a);
    chk(32'(resp), 32'(`DGP_RESP_OKAY), "read resp");
    chk(got, e, "read data");
  endtask
  // -----------------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    // reset: all pins inputs, reads show outside levels
    chk(32'({soe, woe}), 32'h0, "reset enables");
    rchk(`DGP_OFF_SMALL_DIR, 32'h0);
    rchk(`DGP_OFF_WIDE_DIR, 32'h0);
    rchk(`DGP_OFF_SMALL_DATA, 32'hfa);
    rchk(`DGP_OFF_WIDE_DATA, 32'hdc);
    // small port: two outputs, latch bit 2 differs from its input pin
    wchk(`DGP_OFF_SMALL_DATA, 32'h05);
    wchk(`DGP_OFF_SMALL_DIR, 32'h03);
    repeat (2) @(posedge clk);
    chk(32'({soe, so & soe}), 32'h31, "small pins");
    rchk(`DGP_OFF_SMALL_DATA, 32'hf9);
    // wide port with the top pin as a plain output
    wchk(`DGP_OFF_WIDE_DATA, 32'ha5);
    wchk(`DGP_OFF_WIDE_DIR, 32'h8f);
    repeat (4) @(posedge clk);
    chk(32'({woe, wo & woe}), 32'h8f85, "wide pins");
    chk(32'(tpin), 32'h0, "timer input");
    rchk(`DGP_OFF_WIDE_DATA, 32'hd5);
    // timer claims two input pins, bits 4 and 6
    tcl <= 7'h50;
    tout <= 7'h10;
    repeat (4) @(posedge clk);
    chk(32'({woe, wo & woe}), 32'hdf95, "claimed pins");
    rchk(`DGP_OFF_WIDE_DATA, 32'h95);
    tcl <= 7'h00;
    // every row of the top pin decode, timer value toggled per row
    wchk(`DGP_OFF_WIDE_DIR, 32'h0f);
    for (int i = 0; i < 16; i++) begin
      tdo <= i[0];
      exp3 = {tc_drv[i], tc_drv[i] & i[0], ~tc_drv[i]};
      wchk(`DGP_OFF_TIMER_CTRL, 32'(tc_tab[i]));
      repeat (6) @(posedge clk);
      chk(32'(top_seen), 32'(exp3), "top pin");
    end
    rchk(`DGP_OFF_TIMER_CTRL, 32'h108);
    // unmapped places are refused
    rdr(5'h14);
    chk({30'h0, resp} | got, 32'(`DGP_RESP_SLVERR), "unmapped read");
    wr(5'h18, 32'hff);
    chk(32'(resp), 32'(`DGP_RESP_SLVERR), "unmapped write");
    // reset in mid-run puts pins back to inputs and data to zero
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk(32'({soe, woe}), 32'h0, "second reset");
    rchk(`DGP_OFF_TIMER_CTRL, 32'(`DGP_RST_TCTL));
    wchk(`DGP_OFF_WIDE_DIR, 32'hff);
    rchk(`DGP_OFF_WIDE_DATA, 32'h0);
    test_done();
  end
endmodule
`default_nettype wire
